/* File: include/boost_thermal_pkg.sv */
`default_nettype none
package boost_thermal_pkg;

   // register location and reset image
   localparam logic [7:0] CFG_ADDR = 8'h06;
   localparam logic [7:0] CFG_RESET = 8'h73;

   // field positions
   localparam int VCODE_MSB = 7;
   localparam int VCODE_LSB = 4;
   localparam int BHOT_MSB = 3;
   localparam int BHOT_LSB = 2;
   localparam int DIE_TEMP_REGULATION_SELECT_MSB = 1;
   localparam int DIE_TEMP_REGULATION_SELECT_LSB = 0;

   // boost voltage decode, millivolts
   localparam logic [12:0] BOOST_BASE_MV = 13'h11c6;
   localparam int BOOST_STEP_SHIFT = 6;

   // thermistor thresholds, percent of the internal regulator rail
   localparam logic [5:0] PCT_THR_A = 6'h21;
   localparam logic [5:0] PCT_THR_B = 6'h24;
   localparam logic [5:0] PCT_THR_C = 6'h1e;
   localparam logic [5:0] PCT_THR_OFF = 6'h00;

   // die temperature regulation, degrees celsius
   localparam logic [6:0] DIE_TEMP_0 = 7'h3c;
   localparam logic [6:0] DIE_TEMP_1 = 7'h50;
   localparam logic [6:0] DIE_TEMP_2 = 7'h64;
   localparam logic [6:0] DIE_TEMP_3 = 7'h78;

   // number of thermistor comparators
   localparam int NUM_THR = 3;

   // boost temperature threshold selection
   typedef enum logic [1:0] {
      THR_A = 2'b00,
      THR_B = 2'b01,
      THR_C = 2'b10,
      THR_OFF = 2'b11
   } boost_thr_t;

   function automatic logic [5:0] thr_pct(input boost_thr_t sel);
      unique case (sel)
         THR_A: thr_pct = PCT_THR_A;
         THR_B: thr_pct = PCT_THR_B;
         THR_C: thr_pct = PCT_THR_C;
         THR_OFF: thr_pct = PCT_THR_OFF;
      endcase
   endfunction : thr_pct

   function automatic logic [6:0] die_temp(input logic [1:0] sel);
      unique case (sel)
         2'b00: die_temp = DIE_TEMP_0;
         2'b01: die_temp = DIE_TEMP_1;
         2'b10: die_temp = DIE_TEMP_2;
         2'b11: die_temp = DIE_TEMP_3;
      endcase
   endfunction : die_temp

endpackage : boost_thermal_pkg
`default_nettype wire

/* File: design/level_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module level_sync (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // asynchronous level in, synchronised level out
   input wire logic i_async,
   output logic o_sync
);

   logic meta_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : level_sync
`default_nettype wire

/* File: design/boost_thermal_config_reg.sv */
`timescale 1ns/1ns
`default_nettype none
module boost_thermal_config_reg
   import boost_thermal_pkg::*;
(
   // clock and resets
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_soft_rst,
   // register access from the serial control port
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   // thermistor comparators, high when hotter than threshold a, b, c
   input wire logic [NUM_THR-1:0] i_ntc_hot,
   // decoded settings
   output logic [3:0] o_otg_output_voltage_code,
   output logic [12:0] o_boost_voltage_mv,
   output logic [1:0] o_boost_temp_select,
   output logic [5:0] o_boost_temp_pct,
   output logic [1:0] o_die_temp_regulation_select,
   output logic [6:0] o_die_temp_c,
   // boost temperature supervision
   output logic o_boost_stop,
   output logic o_thermistor_fault_flag
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage

   logic [7:0] cfg_q;
   logic [NUM_THR-1:0] hot_s;
   logic wr_hit;
   logic rd_hit;
   boost_thr_t thr_sel;
   boost_thr_t fault_sel;

   function automatic logic hot_of(input boost_thr_t sel, input logic [NUM_THR-1:0] hot);
      unique case (sel)
         THR_A: hot_of = hot[0];
         THR_B: hot_of = hot[1];
         THR_C: hot_of = hot[2];
         THR_OFF: hot_of = 1'b0;
      endcase
   endfunction : hot_of

   assign wr_hit = i_wr_en && (i_addr == CFG_ADDR);
   assign rd_hit = i_rd_en && (i_addr == CFG_ADDR);
   assign thr_sel = boost_thr_t'(cfg_q[BHOT_MSB:BHOT_LSB]);
   assign fault_sel = (thr_sel == THR_OFF) ? THR_A : thr_sel;

   always_ff @(posedge i_clk) begin
      if (i_rst || i_soft_rst) begin
         cfg_q <= CFG_RESET;
      end else if (wr_hit) begin
         cfg_q <= i_wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en;
         o_rd_data <= rd_hit ? cfg_q : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decoded settings

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_otg_output_voltage_code <= 4'h0;
         o_boost_voltage_mv <= BOOST_BASE_MV;
         o_boost_temp_select <= 2'h0;
         o_boost_temp_pct <= PCT_THR_A;
         o_die_temp_regulation_select <= 2'h0;
         o_die_temp_c <= DIE_TEMP_0;
      end else begin
         o_otg_output_voltage_code <= cfg_q[VCODE_MSB:VCODE_LSB];
         o_boost_voltage_mv <= BOOST_BASE_MV
            + (13'(cfg_q[VCODE_MSB:VCODE_LSB]) << BOOST_STEP_SHIFT);
         o_boost_temp_select <= cfg_q[BHOT_MSB:BHOT_LSB];
         o_boost_temp_pct <= thr_pct(thr_sel);
         o_die_temp_regulation_select <= cfg_q[DIE_TEMP_REGULATION_SELECT_MSB:DIE_TEMP_REGULATION_SELECT_LSB];
         o_die_temp_c <= die_temp(cfg_q[DIE_TEMP_REGULATION_SELECT_MSB:DIE_TEMP_REGULATION_SELECT_LSB]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // thermistor supervision

   for (genvar g = 0; g < NUM_THR; g++) begin : g_sync
      level_sync u_sync (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_async(i_ntc_hot[g]),
         .o_sync(hot_s[g])
      );
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_boost_stop <= 1'b0;
         o_thermistor_fault_flag <= 1'b0;
      end else begin
         o_boost_stop <= hot_of(thr_sel, hot_s);
         o_thermistor_fault_flag <= hot_of(fault_sel, hot_s);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_soft_reset_value:
      assert property (i_soft_rst |=> cfg_q == 8'h73)
      else $error("soft reset did not load 0x73");

   a_write_stores_value:
      assert property (wr_hit && !i_soft_rst |=> cfg_q == $past(i_wr_data))
      else $error("write not stored");

   a_no_write_holds:
      assert property (!wr_hit && !i_soft_rst |=> $stable(cfg_q))
      else $error("register changed without write");

   a_read_returns_write:
      assert property (wr_hit && !i_soft_rst ##1 rd_hit && !wr_hit
                       |=> o_rd_valid && o_rd_data == $past(i_wr_data, 2))
      else $error("read did not return last write");

   a_voltage_decode:
      assert property (wr_hit && !i_soft_rst && i_wr_data[7:4] == 4'h7
                       |=> ##1 o_boost_voltage_mv == 13'h1386)
      else $error("boost voltage decode wrong");

   a_threshold_pct:
      assert property (thr_sel == THR_B |=> o_boost_temp_pct == 6'h24)
      else $error("threshold percent wrong");

   a_stop_on_hot:
      assert property (thr_sel == THR_C && hot_s[2] |=> o_boost_stop)
      else $error("boost not stopped on crossing");

   a_no_stop_when_off:
      assert property (thr_sel == THR_OFF && hot_s[0]
                       |=> !o_boost_stop && o_thermistor_fault_flag)
      else $error("disabled check misbehaved");

   a_die_temp_decode:
      assert property (cfg_q[1:0] == 2'b01 |=> o_die_temp_c == 7'h50)
      else $error("die temperature decode wrong");

   a_soft_beats_write:
      assert property (i_soft_rst && wr_hit |=> cfg_q == CFG_RESET)
      else $error("write won over soft reset");

   a_read_valid_pulse:
      assert property (i_rd_en |=> o_rd_valid)
      else $error("read strobe gave no valid");

   a_read_valid_idle:
      assert property (!i_rd_en |=> !o_rd_valid)
      else $error("valid without read strobe");

   a_read_data_current:
      assert property (rd_hit |=> o_rd_data == $past(cfg_q))
      else $error("read data not the stored value");

   a_unmapped_read_zero:
      assert property (i_rd_en && !rd_hit |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");

   a_voltage_lowest:
      assert property (cfg_q[7:4] == 4'h0 |=> o_boost_voltage_mv == 13'h11c6)
      else $error("lowest boost voltage wrong");

   a_voltage_highest:
      assert property (cfg_q[7:4] == 4'hf |=> o_boost_voltage_mv == 13'h1586)
      else $error("highest boost voltage wrong");

   a_threshold_a_pct:
      assert property (thr_sel == THR_A |=> o_boost_temp_pct == 6'h21)
      else $error("threshold a percent wrong");

   a_threshold_c_pct:
      assert property (thr_sel == THR_C |=> o_boost_temp_pct == 6'h1e)
      else $error("threshold c percent wrong");

   a_threshold_off_pct:
      assert property (thr_sel == THR_OFF |=> o_boost_temp_pct == 6'h00)
      else $error("disabled threshold percent wrong");

   a_stop_hot_a:
      assert property (thr_sel == THR_A && hot_s[0]
                       |=> o_boost_stop && o_thermistor_fault_flag)
      else $error("boost not stopped on threshold a");

   a_no_stop_cool:
      assert property (thr_sel == THR_B && !hot_s[1] |=> !o_boost_stop)
      else $error("boost stopped while cool");

   a_off_fault_cool:
      assert property (thr_sel == THR_OFF && !hot_s[0] |=> !o_thermistor_fault_flag)
      else $error("fault raised while cool with check off");

   a_die_temp_low:
      assert property (cfg_q[1:0] == 2'b00 |=> o_die_temp_c == 7'h3c)
      else $error("lowest die temperature decode wrong");

   a_die_temp_high:
      assert property (cfg_q[1:0] == 2'b11 |=> o_die_temp_c == 7'h78)
      else $error("highest die temperature decode wrong");

endmodule : boost_thermal_config_reg
`default_nettype wire

/* File: dv/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // clock
   input wire logic i_clk,
   // register port
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [7:0] o_addr,
   output logic [7:0] o_wr_data,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_valid
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 8'h00;
      o_wr_data = 8'h00;
   end
   // write: held through the taking edge, then released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(posedge i_clk) #1;
      o_wr_en = 1'b0;
      o_addr = ~a;
      o_wr_data = ~d;
   endtask : wr
   // read: answer is sampled the cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge i_clk) #1;
      o_addr = a;
      o_rd_en = 1'b1;
      @(posedge i_clk) #1;
      o_rd_en = 1'b0;
      o_addr = ~a;
      d = i_rd_data;
      v = i_rd_valid;
   endtask : rd
   // write, then read on the very next edge with no idle cycle between
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
      output logic v);
      @(posedge i_clk) #1;
      o_addr = a;
      o_wr_data = wd;
      o_wr_en = 1'b1;
      @(posedge i_clk) #1;
      o_wr_en = 1'b0;
      o_wr_data = ~wd;
      o_rd_en = 1'b1;
      @(posedge i_clk) #1;
      o_rd_en = 1'b0;
      o_addr = ~a;
      d = i_rd_data;
      v = i_rd_valid;
   endtask : wr_rd
endmodule : host_model
`default_nettype wire

/* File: dv/boost_thermal_config_reg_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module boost_thermal_config_reg_tb;
   import boost_thermal_pkg::*;
   logic clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, wr_en, rd_en, rd_valid, stop, fault, vl;
   logic [7:0] addr, wr_data, rd_data, d;
   logic [2:0] hot = 3'h0;
   logic [3:0] code;
   logic [12:0] mv;
   logic [1:0] bsel, tsel;
   logic [5:0] pct;
   logic [6:0] temp;
   int miscompares = 0, n_tests = 0;
   always #10 clk = ~clk;
   host_model i_host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
      .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_valid(rd_valid));
   boost_thermal_config_reg i_dut (.i_clk(clk), .i_rst(rst), .i_soft_rst(soft_rst),
      .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_ntc_hot(hot),
      .o_otg_output_voltage_code(code), .o_boost_voltage_mv(mv),
      .o_boost_temp_select(bsel), .o_boost_temp_pct(pct),
      .o_die_temp_regulation_select(tsel), .o_die_temp_c(temp),
      .o_boost_stop(stop), .o_thermistor_fault_flag(fault));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // read back and check every decoded output against the image v
   task automatic exp_cfg(input logic [7:0] v);
      logic [5:0] p;
      p = (v[3:2] == 2'b00) ? 6'd33 : (v[3:2] == 2'b01) ? 6'd36 : (v[3:2] == 2'b10) ? 6'd30 : 6'd0;
      i_host.rd(CFG_ADDR, d, vl);
      chk("rd_data", d, v);
      chk("rd_valid", vl, 1'b1);
      chk("code", code, v[7:4]);
      chk("mv", mv, 16'd4550 + 16'd64 * v[7:4]);
      chk("bsel", bsel, v[3:2]);
      chk("pct", pct, p);
      chk("tsel", tsel, v[1:0]);
      chk("temp", temp, 7'd60 + 7'd20 * v[1:0]);
   endtask : exp_cfg
   task automatic t_fields();
      logic [7:0] tab [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
      foreach (tab[i]) begin
         i_host.wr(CFG_ADDR, tab[i]);
         exp_cfg(tab[i]);
      end
   endtask : t_fields
   task automatic t_unmapped();
      i_host.wr(8'h07, 8'h00);
      i_host.rd(8'h05, d, vl);
      chk("unmapped", d, 8'h00);
      chk("unmapped_valid", vl, 1'b1);
      exp_cfg(8'hff);
   endtask : t_unmapped
   task automatic thermo(input logic [1:0] s, input logic [2:0] h, input logic es, input logic ef);
      i_host.wr(CFG_ADDR, {4'h7, s, 2'b11});
      hot = h;
      repeat (4) @(posedge clk);
      #1;
      chk("stop", stop, es);
      chk("fault", fault, ef);
      hot = 3'h0;
   endtask : thermo
   task automatic t_soft();
      soft_rst = 1'b1;
      i_host.wr(CFG_ADDR, 8'h00);
      soft_rst = 1'b0;
      exp_cfg(8'h73);
   endtask : t_soft
   task automatic t_back_to_back();
      i_host.wr_rd(CFG_ADDR, 8'h3c, d, vl);
      chk("b2b_data", d, 8'h3c);
      chk("b2b_valid", vl, 1'b1);
      exp_cfg(8'h3c);
   endtask : t_back_to_back
   task automatic t_hard_rst();
      i_host.wr(CFG_ADDR, 8'h00);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("rst_code", code, 4'h0);
      chk("rst_valid", rd_valid, 1'b0);
      rst = 1'b0;
      exp_cfg(8'h73);
   endtask : t_hard_rst
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      exp_cfg(8'h73);
      t_fields();
      t_unmapped();
      t_back_to_back();
      thermo(2'b00, 3'b001, 1'b1, 1'b1);
      thermo(2'b01, 3'b001, 1'b0, 1'b0);
      thermo(2'b01, 3'b010, 1'b1, 1'b1);
      thermo(2'b10, 3'b100, 1'b1, 1'b1);
      thermo(2'b11, 3'b001, 1'b0, 1'b1);
      thermo(2'b11, 3'b110, 1'b0, 1'b0);
      t_hard_rst();
      t_soft();
      end_sim();
   end
endmodule : boost_thermal_config_reg_tb
`default_nettype wire
